// [dv/serial_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module serial_host_model (
	// Link, host side
	output logic lclk,
	output logic cs_n,
	output wire chain,
	// Observed pins
	input wire sclk,
	input wire sdo,
	input wire oe_n,
	input wire inv,
	// Captured word
	output logic [33:0] got
);
	initial {lclk, cs_n} = 2'h1;
	// Upstream converter streams ones while selected
	assign chain = !cs_n;
	// Sample at the active edge, before the device steps
	always @(sclk)
		if (!oe_n && sclk != inv)
			got <= {got[32:0], sdo};
	task automatic frame;
		lclk = inv;
		#125 cs_n = 1'h0;
		repeat (34)
		begin
			#62 lclk = !lclk;
			#63 lclk = !lclk;
		end
		#125 cs_n = 1'h1;
	endtask
endmodule // serial_host_model
`default_nettype wire

// [dv/serial_result_port_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module serial_result_port_sva (
	// Bus
	input wire hclk,
	input wire hresetn,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hreadyout,
	input wire hresp,
	// Pins
	input wire chip_select_n,
	input wire serial_result_out,
	input wire serial_result_out_oe_n,
	input wire serial_result_clock_in,
	input wire serial_result_clock,
	input wire serial_result_clock_oe_n,
	input wire parallel_bit_twelve
);
	logic [2:0] w_r;
	logic oe_r, out_r;
	wire oe = !serial_result_out_oe_n;
	wire slv = serial_result_clock_oe_n;
	// A write landed one or two cycles back
	wire wr = |w_r[2:1];
	wire mv = oe && oe_r && serial_result_out != out_r;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	always @(posedge hclk or negedge hresetn)
		if (!hresetn)
			{w_r, oe_r, out_r} <= 5'h0;
		else
			{w_r, oe_r, out_r} <= {w_r[1:0], htrans == 2'h2 && hwrite, oe,
				serial_result_out};
	a_bus_okay: assert property (hreadyout && !hresp) else $error("bus");
	a_twelve_write: assert property
		($changed(parallel_bit_twelve) |-> wr) else $error("bit twelve");
	a_clkdir_write: assert property
		($changed(serial_result_clock_oe_n) |-> wr) else $error("clock dir");
	a_start_write: assert property
		($fell(serial_result_out_oe_n) |-> wr) else $error("enable");
	a_slave_step: assert property
		(slv && mv |-> $past(serial_result_clock_in)
		!= $past(serial_result_clock_in, 6)) else $error("step off edge");
	a_slave_gated: assert property
		(slv && mv |-> !$past(chip_select_n, 3)) else $error("not selected");
	a_master_even: assert property
		(!slv && mv && !wr |-> $changed(serial_result_clock))
		else $error("data off clock");
	a_frame_open: assert property
		($fell(serial_result_out_oe_n) && slv |=> oe [*8])
		else $error("frame cut");
	c_slave: cover property (slv && mv);
	c_master: cover property (!slv && oe && $changed(serial_result_clock));
	c_done: cover property ($rose(serial_result_out_oe_n));
endmodule // serial_result_port_sva
bind serial_result_port serial_result_port_sva chk_u (.*);
`default_nettype wire

// [dv/serial_result_port_test.sv]
`timescale 1ns/1ns
`default_nettype none
module serial_result_port_test;
	logic hclk = 1'h0, hresetn = 1'h0, hwrite = 1'h0, inv = 1'h0;
	logic [1:0] htrans = 2'h0;
	logic [11:0] haddr = 12'h0;
	logic [31:0] hwdata = 32'h0, rd;
	wire [31:0] hrdata;
	wire [33:0] got;
	wire hreadyout, hresp, serial_result_out, serial_result_out_oe_n,
		serial_result_clock_in, serial_result_clock, serial_result_clock_oe_n,
		parallel_bit_twelve, chip_select_n, chain_input;
	wire [4:0] pins_seen = {serial_result_out, serial_result_clock,
		parallel_bit_twelve, serial_result_out_oe_n, serial_result_clock_oe_n};
	int miscompares = 0, checks = 0, cyc = 0;
	always #2 hclk = !hclk;
	serial_result_port #(.DIV_HALF(2)) dut_u (.*, .hsel(1'h1),
		.hsize(3'h2), .hready(hreadyout));
	serial_host_model host_u (.lclk(serial_result_clock_in),
		.cs_n(chip_select_n), .chain(chain_input), .sdo(serial_result_out),
		.sclk(serial_result_clock_oe_n ? serial_result_clock_in
		: serial_result_clock), .oe_n(serial_result_out_oe_n), .inv, .got);
	task automatic check(input logic [33:0] seen, exp);
		checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %0t %h %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge hclk);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		rd = hrdata;
	endtask
	task automatic pins;
		bus(1'h0, 12'h000, 32'h0);
		check(rd, 34'h0);
		bus(1'h1, 12'h00c, 32'h5);
		repeat (2) @(posedge hclk);
		check(pins_seen, 34'h14);
		bus(1'h0, 12'h010, 32'h0);
		check(rd, 34'h0);
	endtask
	task automatic slave(input logic i, c, input logic [17:0] r);
		inv <= i;
		bus(1'h1, 12'h004, {14'h0, r});
		bus(1'h1, 12'h000, {23'h0, 1'h1, 3'h0, c, i, 3'h7});
		host_u.frame();
		repeat (8) @(posedge hclk);
		check(got, {r ^ {!c, 17'h0}, 16'hffff});
		check(serial_result_out_oe_n, 34'h1);
	endtask
	task automatic master;
		inv <= 1'h0;
		bus(1'h1, 12'h004, 32'h30c0a);
		bus(1'h1, 12'h000, 32'h113);
		repeat (2) @(posedge hclk);
		check(pins_seen[1:0], 34'h0);
		bus(1'h0, 12'h008, 32'h0);
		check(rd, 34'h3);
		while (serial_result_out_oe_n !== 1'h1)
			@(posedge hclk);
		check(got, {18'h30c0a, 16'h0});
	endtask
	// Ceiling is several times the longest expected run
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			stop_test;
		end
	end
	initial
	begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'h1;
		pins;
		slave(1'h0, 1'h1, 18'h2c0f0);
		slave(1'h1, 1'h0, 18'h1a5c3);
		master;
		stop_test;
	end
endmodule // serial_result_port_test
`default_nettype wire

// [hw/serial_result_port.v]
// Behaviour
// - Chain input reaches output after eighteen periods
// - Slave mode accepts upstream converter serial data
// - Parallel modes: shared pin drives bit ten
// - Mode three: pin is serial result output
// - Result held, shifted out MSB first
// - Coding select picks offset binary or two's
// - Master: bit changes on the inactive clock edge
// - Slave, invert low: update on rising edge
// - Slave, invert high: update on falling edge
// - Mode three: clock source select sets clock pin direction
// - Parallel modes: clock pin drives bit eleven
// - Parallel modes: neighbour pin drives bit twelve
// - Source low master drives clock; high slave
// - Invert select chooses active edge: low rising
`timescale 1ns/1ns
`default_nettype none
`include "serial_result_regs.vh"

module serial_result_port #(
	parameter WIDTH    = 18,
	parameter DIV_HALF = 4
)(
	// Clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [11:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire        hready,
	input  wire [31:0] hwdata,
	output wire [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	// Chip select from host, gates the external clock
	input  wire        chip_select_n,
	// Shared data pin: serial result or parallel bit ten
	output wire        serial_result_out,
	output wire        serial_result_out_oe_n,
	// Shared clock pin: serial clock or parallel bit eleven
	input  wire        serial_result_clock_in,
	output wire        serial_result_clock,
	output wire        serial_result_clock_oe_n,
	// Parallel bit twelve, chain input
	output wire        parallel_bit_twelve,
	input  wire        chain_input
);

	localparam CW = 8;
	localparam ST_IDLE  = 2'h0;
	localparam ST_SHIFT = 2'h1;

	reg  [1:0]       mode_r;
	reg              clk_src_r;
	reg              invert_r;
	reg              coding_r;
	reg  [WIDTH-1:0] result_r;
	reg              loaded_r;
	reg  [31:0]      hrdata_r;
	reg              ph_valid_r;
	reg              ph_write_r;
	reg  [11:0]      ph_addr_r;
	reg              ph_word_r;

	reg  [1:0]       state_r;
	reg  [WIDTH-1:0] shift_r;
	reg              cs_seen_r;
	reg  [7:0]       bit_cnt_r;
	reg              sdo_r;
	reg  [CW-1:0]    div_r;
	reg              mclk_r;
	reg              start_r;
	reg  [2:0]       pin_clk_s;
	reg  [1:0]       cs_s;
	reg  [1:0]       chain_s;
	reg  [2:0]       par_r;

	wire serial_mode = (mode_r == `MODE_SERIAL);
	wire master      = ~clk_src_r;
	wire [WIDTH-1:0] coded = coding_r ? result_r
		: {~result_r[WIDTH-1], result_r[WIDTH-2:0]};

	// AHB address phase capture
	wire take = hsel & hready & (htrans == `HTRANS_NONSEQ);
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ph_valid_r <= 1'b0;
			ph_write_r <= 1'b0;
			ph_addr_r  <= 12'h000;
			ph_word_r  <= 1'b0;
		end
		else if (hready)
		begin
			ph_valid_r <= take;
			ph_write_r <= hwrite;
			ph_addr_r  <= haddr;
			ph_word_r  <= (hsize == `HSIZE_WORD);
		end
	end

	// Registers take whole words only; narrower writes are ignored
	wire wr = ph_valid_r & ph_write_r & ph_word_r;
	wire rd = take & ~hwrite;

	// Register writes; start is a one-cycle request
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mode_r    <= 2'h0;
			clk_src_r <= 1'b0;
			invert_r  <= 1'b0;
			coding_r  <= 1'b0;
			result_r  <= {WIDTH{1'b0}};
			start_r   <= 1'b0;
			par_r     <= 3'h0;
		end
		else
		begin
			start_r <= 1'b0;
			if (wr && ph_addr_r == `REG_CTRL)
			begin
				mode_r    <= hwdata[`CTRL_MODE_HI:`CTRL_MODE_LO];
				clk_src_r <= hwdata[`CTRL_CLK_SRC];
				invert_r  <= hwdata[`CTRL_INVERT];
				coding_r  <= hwdata[`CTRL_CODING];
				start_r   <= hwdata[`CTRL_START];
			end
			if (wr && ph_addr_r == `REG_RESULT)
				result_r <= hwdata[WIDTH-1:0];
			if (wr && ph_addr_r == `REG_PARALLEL)
				par_r <= hwdata[`PAR_MSB:0];
		end
	end

	// Read data registered in the address phase, valid in data phase
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata_r <= 32'h0000_0000;
		else if (rd)
		begin
			case (haddr)
			`REG_CTRL:
				hrdata_r <= {27'h0, coding_r, invert_r, clk_src_r,
					mode_r};
			`REG_RESULT:
				hrdata_r <= {{(32-WIDTH){1'b0}}, result_r};
			`REG_STATUS:
				hrdata_r <= {30'h0, loaded_r, state_r == ST_SHIFT};
			`REG_PARALLEL:
				hrdata_r <= {29'h0, par_r};
			default:
				hrdata_r <= 32'h0000_0000;
			endcase
		end
	end

	assign hrdata    = hrdata_r;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Pin synchronisers; first stage feeds only the second
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_clk_s <= 3'h0;
			cs_s      <= 2'h3;
			chain_s   <= 2'h0;
		end
		else
		begin
			pin_clk_s <= {pin_clk_s[1:0], serial_result_clock_in};
			cs_s      <= {cs_s[0], chip_select_n};
			chain_s   <= {chain_s[0], chain_input};
		end
	end

	wire ext_rise = pin_clk_s[1] & ~pin_clk_s[2];
	wire ext_fall = ~pin_clk_s[1] & pin_clk_s[2];
	wire ext_edge = ~cs_s[1] & (invert_r ? ext_fall : ext_rise);

	// Master clock divider; data changes at the inactive edge so it
	// is settled half a period either side of the active edge
	wire div_end = (div_r == DIV_HALF[CW-1:0] - 8'h01);
	wire m_update = div_end & (mclk_r ^ invert_r);
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			div_r  <= {CW{1'b0}};
			mclk_r <= 1'b0;
		end
		else if (state_r == ST_SHIFT && master)
		begin
			div_r <= div_end ? {CW{1'b0}} : div_r + 8'h01;
			if (div_end)
				mclk_r <= ~mclk_r;
		end
		else
		begin
			div_r  <= {CW{1'b0}};
			mclk_r <= invert_r;
		end
	end

	// slave shifts on the selected external edge
	wire step = master ? m_update : ext_edge;
	// Result word plus the chained bits that follow it
	wire [31:0] total_w = WIDTH + `CHAIN_DELAY;
	wire [7:0]  total   = total_w[7:0];

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_r   <= ST_IDLE;
			shift_r   <= {WIDTH{1'b0}};
			cs_seen_r <= 1'b0;
			bit_cnt_r <= 8'h00;
			sdo_r     <= 1'b0;
			loaded_r  <= 1'b0;
		end
		else
		begin
			case (state_r)
			ST_IDLE:
				if (start_r && serial_mode)
				begin
					shift_r   <= coded;
					cs_seen_r <= 1'b0;
					sdo_r     <= coded[WIDTH-1];
					bit_cnt_r <= 8'h01;
					loaded_r  <= 1'b1;
					state_r   <= ST_SHIFT;
				end
			ST_SHIFT:
			begin
				if (!cs_s[1])
					cs_seen_r <= 1'b1;
				if (!serial_mode)
				begin
					state_r  <= ST_IDLE;
					loaded_r <= 1'b0;
				end
				// In slave mode, a host that lifts its select mid-word has cut the
				// frame: give up the rest rather than hang in shift
				else if (!master && cs_seen_r && cs_s[1])
				begin
					state_r  <= ST_IDLE;
					loaded_r <= 1'b0;
				end
				else if (step)
				begin
					// Chain bits enter at the tail and surface right
					// after the result word, one bit per period
					shift_r <= {shift_r[WIDTH-2:0],
						chain_s[1]};
					sdo_r   <= shift_r[WIDTH-2];
					if (bit_cnt_r == total)
					begin
						state_r  <= ST_IDLE;
						loaded_r <= 1'b0;
					end
					bit_cnt_r <= bit_cnt_r + 8'h01;
				end
			end
			default:
				state_r <= ST_IDLE;
			endcase
		end
	end

	// Shared pins; in a parallel mode every pin is a driven bus bit,
	// so both enables stay low there
	wire par_ten    = par_r[`PAR_BIT_TEN];
	wire par_eleven = par_r[`PAR_BIT_ELEVEN];
	wire out_idle   = (state_r != ST_SHIFT);
	assign serial_result_out = serial_mode
		? sdo_r
		: par_ten;
	assign serial_result_out_oe_n = serial_mode
		? out_idle
		: 1'b0;
	assign serial_result_clock = serial_mode
		? mclk_r
		: par_eleven;
	assign serial_result_clock_oe_n = serial_mode
		? clk_src_r
		: 1'b0;
	assign parallel_bit_twelve = par_r[`PAR_BIT_TWELVE];

endmodule // serial_result_port
`default_nettype wire

// [hw/serial_result_regs.vh]
`ifndef SERIAL_RESULT_REGS_VH
`define SERIAL_RESULT_REGS_VH

// Register byte offsets
`define REG_CTRL        12'h000
`define REG_RESULT      12'h004
`define REG_STATUS      12'h008
`define REG_PARALLEL    12'h00c

// Control fields
`define CTRL_MODE_LO    0
`define CTRL_MODE_HI    1
`define CTRL_CLK_SRC    2
`define CTRL_INVERT     3
`define CTRL_CODING     4
`define CTRL_START      8

// Status fields
`define STAT_BUSY       0
`define STAT_LOADED     1

// Serial interface selection value
`define MODE_SERIAL     2'h3

// Chain delay in serial clock periods
`define CHAIN_DELAY     16

// AHB encodings
`define HTRANS_NONSEQ   2'h2
`define HSIZE_WORD      3'h2

// Parallel register bit positions
`define PAR_BIT_TEN     0
`define PAR_BIT_ELEVEN  1
`define PAR_BIT_TWELVE  2
`define PAR_MSB         2

`endif
